// file: pkg/aop_pkg.sv
// Constants shared by the sample output port design
package aop_pkg;

  // Word and pin counts
  localparam int unsigned RES_W     = 12;
  localparam int unsigned DDR_PAIRS = 7;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ANALOG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_DDR_BIT   = 0;
  localparam int unsigned CTRL_OFFS_BIT  = 1;
  localparam int unsigned CTRL_SHIFT_BIT = 2;
  localparam int unsigned CTRL_OFF_BIT   = 3;
  localparam int unsigned CTRL_PIN_BIT   = 4;
  localparam int unsigned CTRL_DRIVE_BIT = 5;
  localparam int unsigned CTRL_W         = 6;
  localparam logic [5:0]  CTRL_RST       = 6'h00;

  // Analog setting register fields
  localparam int unsigned AN_CUR_LSB    = 0;
  localparam int unsigned AN_BOOST_BIT  = 2;
  localparam int unsigned AN_DTERM_LSB  = 4;
  localparam int unsigned AN_CTERM_LSB  = 8;
  localparam logic [10:0] ANALOG_RST    = 11'h000;
  localparam logic [10:0] ANALOG_MASK   = 11'h777;

  // Status register fields
  localparam int unsigned ST_DDR_BIT   = 0;
  localparam int unsigned ST_OFFS_BIT  = 1;
  localparam int unsigned ST_VALID_BIT = 2;
  localparam int unsigned ST_PIN_BIT   = 3;

  // Differential current codes
  typedef enum logic [1:0] {
    AOP_CUR_3P5  = 2'h0,
    AOP_CUR_2P5  = 2'h1,
    AOP_CUR_4P5  = 2'h2,
    AOP_CUR_1P75 = 2'h3
  } aop_cur_t;

  // Settling time after buffers are re-enabled
  localparam int unsigned CLK_PERIOD_PS  = 10000;
  localparam int unsigned SETTLE_NS      = 200;
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_W       = 8;

endpackage : aop_pkg

// file: pkg/aop_sync_if.sv
// Level bundle carried across a clock boundary
`timescale 1ns/1ps
interface aop_sync_if #(
  parameter int unsigned W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport feed (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : aop_sync_if

// file: logic/aop_sync.sv
// Two-stage level synchroniser for a bundle of slow levels
`timescale 1ns/1ps
module aop_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level bundle
  aop_sync_if.sync  bus
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= bus.raw;
      sync_q <= meta_q;
    end
  end

  assign bus.synced = sync_q;

endmodule : aop_sync

// file: logic/aop_port.sv
// Sample output port: APB settings, parallel and DDR output formatter
//
// Contract
// - Each sample period deliver one 12-bit result with a forwarded clock
// - Interface type chosen by register bit or by configuration pin
// - Parallel mode: one pin per bit, full word every sample period
// - Clock shift setting delays forwarded clock to lengthen setup; ignored here in DDR mode
// - Drive strength defaults reduced; setting selects stronger drive
// - DDR mode: two bits per pair per period, 7 data pairs
// - DDR even bits launched at clock rise, odd bits at fall
// - Current setting picks 3.5, 2.5, 4.5 or 1.75 mA
// - Current boost doubles data and clock pair current
// - Three termination branches in any combination, eight settings
// - Data pairs and clock pair termination set separately
// - Result in two's complement or offset binary, bit or pin
// - Buffer off floats outputs; valid data within 200 ns after
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module aop_port (
  // APB clock, reset and slave
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Configuration pin
  input  wire logic                          parallel_config_pin,
  // Converter side, bit clock domain
  input  wire logic                          bit_clk,
  input  wire logic [aop_pkg::RES_W-1:0]     conv_data,
  // Parallel single-ended pins
  output logic      [aop_pkg::RES_W-1:0]     par_data,
  output logic                               par_data_oe,
  // Differential data pairs
  output logic      [aop_pkg::DDR_PAIRS-1:0] pair_true,
  output logic      [aop_pkg::DDR_PAIRS-1:0] pair_comp,
  output logic                               pair_oe,
  // Forwarded clock
  output logic                               output_clock,
  output logic                               output_clock_true,
  output logic                               output_clock_comp,
  output logic                               clock_oe,
  // Static analog settings
  output logic                               buffer_drive_level,
  output logic      [1:0]                    diff_current_level,
  output logic                               current_boost,
  output logic      [2:0]                    data_pair_termination,
  output logic      [2:0]                    clock_pair_termination
);

  // Register file state
  logic [aop_pkg::CTRL_W-1:0] ctrl_q;
  logic [10:0]                analog_q;
  logic [31:0]                prdata_q;
  logic                       pready_q;
  logic                       pslverr_q;

  // Effective mode, pclk domain
  logic ddr_eff_q;
  logic offs_eff_q;
  logic valid_q;
  logic [aop_pkg::SETTLE_W-1:0] settle_q;

  // Analog settings outputs
  logic                  drive_q;
  logic [1:0]            cur_q;
  logic                  boost_q;
  logic [2:0]            dterm_q;
  logic [2:0]            cterm_q;

  // Link side state
  logic                            ph_q;
  logic [aop_pkg::RES_W-1:0]       word_q;
  logic [aop_pkg::RES_W-1:0]       par_q;
  logic [aop_pkg::DDR_PAIRS-1:0]   ptrue_q;
  logic [aop_pkg::DDR_PAIRS-1:0]   pcomp_q;
  logic                            oclk_q;
  logic                            oclk_t_q;
  logic                            oclk_c_q;
  logic                            par_oe_q;
  logic                            pair_oe_q;
  logic                            clk_oe_q;

  // Synchroniser bundles
  aop_sync_if #(.W(1)) pin_if ();
  aop_sync_if #(.W(4)) cfg_if ();

  logic pin_s;
  logic ddr_s;
  logic offs_s;
  logic shift_s;
  logic en_s;

  // Word on the decode path
  function automatic logic [31:0] reg_read(
    input logic [7:0]                 addr,
    input logic [aop_pkg::CTRL_W-1:0] ctrl,
    input logic [10:0]                analog,
    input logic [3:0]                 status
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      aop_pkg::CTRL_OFS:   v = {26'h0, ctrl};
      aop_pkg::ANALOG_OFS: v = {21'h0, analog};
      aop_pkg::STATUS_OFS: v = {28'h0, status};
      default:             v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == aop_pkg::CTRL_OFS) || (addr == aop_pkg::ANALOG_OFS) ||
           (addr == aop_pkg::STATUS_OFS);
  endfunction : is_mapped

  logic [3:0] status_w;
  assign status_w = {pin_s, valid_q, offs_eff_q, ddr_eff_q};

  // Pin level into pclk domain
  assign pin_if.raw = parallel_config_pin;
  assign pin_s      = pin_if.synced;

  aop_sync #(.W(1)) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .bus   (pin_if)
  );

  // APB writes take effect in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= aop_pkg::CTRL_RST;
      analog_q <= aop_pkg::ANALOG_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == aop_pkg::CTRL_OFS) begin
        ctrl_q <= pwdata[aop_pkg::CTRL_W-1:0];
      end
      if (paddr == aop_pkg::ANALOG_OFS) begin
        analog_q <= pwdata[10:0] & aop_pkg::ANALOG_MASK;
      end
    end
  end

  // Read data and error prepared in the setup phase, zero wait answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (psel && !penable) begin
        prdata_q  <= pwrite ? 32'h0000_0000 :
                     reg_read(paddr, ctrl_q, analog_q, status_w);
        pslverr_q <= !is_mapped(paddr);
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Interface type and number format from register or pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddr_eff_q  <= 1'b0;
      offs_eff_q <= 1'b0;
    end else if (ctrl_q[aop_pkg::CTRL_PIN_BIT]) begin
      ddr_eff_q  <= pin_s;
      offs_eff_q <= pin_s;
    end else begin
      ddr_eff_q  <= ctrl_q[aop_pkg::CTRL_DDR_BIT];
      offs_eff_q <= ctrl_q[aop_pkg::CTRL_OFFS_BIT];
    end
  end

  // Settle count after buffers come back on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q   <= '0;
      valid_q    <= 1'b0;
    end else begin
      if (ctrl_q[aop_pkg::CTRL_OFF_BIT]) begin
        settle_q <= '0;
        valid_q  <= 1'b0;
      end else if (settle_q ==
                   aop_pkg::SETTLE_W'(aop_pkg::SETTLE_CYC - 1)) begin
        valid_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 1'b1;
      end
    end
  end

  // Static analog settings driven from registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 1'b0;
      cur_q   <= aop_pkg::AOP_CUR_3P5;
      boost_q <= 1'b0;
      dterm_q <= 3'h0;
      cterm_q <= 3'h0;
    end else begin
      drive_q <= ctrl_q[aop_pkg::CTRL_DRIVE_BIT];
      cur_q   <= analog_q[aop_pkg::AN_CUR_LSB +: 2];
      boost_q <= analog_q[aop_pkg::AN_BOOST_BIT];
      dterm_q <= analog_q[aop_pkg::AN_DTERM_LSB +: 3];
      cterm_q <= analog_q[aop_pkg::AN_CTERM_LSB +: 3];
    end
  end

  assign buffer_drive_level     = drive_q;
  assign diff_current_level     = cur_q;
  assign current_boost          = boost_q;
  assign data_pair_termination  = dterm_q;
  assign clock_pair_termination = cterm_q;

  // Settings into the bit clock domain
  assign cfg_if.raw = {valid_q, ctrl_q[aop_pkg::CTRL_SHIFT_BIT],
                       offs_eff_q, ddr_eff_q};
  assign {en_s, shift_s, offs_s, ddr_s} = cfg_if.synced;

  aop_sync #(.W(4)) u_cfg_sync (
    .clk   (bit_clk),
    .rst_n (presetn),
    .bus   (cfg_if)
  );

  // Two bit clock phases per sample period
  always_ff @(posedge bit_clk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= !ph_q;
    end
  end

  // New word at the start of each sample period
  always_ff @(posedge bit_clk or negedge presetn) begin
    if (!presetn) begin
      word_q <= '0;
      par_q  <= '0;
    end else if (ph_q) begin
      word_q <= offs_s ? {~conv_data[aop_pkg::RES_W-1],
                          conv_data[aop_pkg::RES_W-2:0]}
                       : conv_data;
      par_q  <= offs_s ? {~conv_data[aop_pkg::RES_W-1],
                          conv_data[aop_pkg::RES_W-2:0]}
                       : conv_data;
    end
  end

  // Pairs: even bits first half, odd bits second half of the period
  for (genvar i = 0; i < aop_pkg::DDR_PAIRS; i++) begin : g_pair
    localparam int unsigned EV = 2 * i;
    localparam int unsigned OD = 2 * i + 1;
    logic ev_bit;
    logic od_bit;
    if (OD < aop_pkg::RES_W) begin : g_live
      assign ev_bit = offs_s && (EV == aop_pkg::RES_W - 1) ?
                      ~conv_data[EV] : conv_data[EV];
      assign od_bit = word_q[OD];
    end else begin : g_spare
      assign ev_bit = 1'b0;
      assign od_bit = 1'b0;
    end
    always_ff @(posedge bit_clk or negedge presetn) begin
      if (!presetn) begin
        ptrue_q[i] <= 1'b0;
        pcomp_q[i] <= 1'b1;
      end else if (ph_q) begin
        ptrue_q[i] <= ev_bit;
        pcomp_q[i] <= ~ev_bit;
      end else begin
        ptrue_q[i] <= od_bit;
        pcomp_q[i] <= ~od_bit;
      end
    end
  end

  // Forwarded clock on the falling bit clock edge, late in parallel mode;
  // a whole-cycle shift in DDR mode would swap the edge order, so none
  always_ff @(negedge bit_clk or negedge presetn) begin
    if (!presetn) begin
      oclk_q   <= 1'b0;
      oclk_t_q <= 1'b0;
      oclk_c_q <= 1'b1;
    end else begin
      oclk_q   <= (shift_s && !ddr_s) ? ph_q : !ph_q;
      oclk_t_q <= (shift_s && !ddr_s) ? ph_q : !ph_q;
      oclk_c_q <= (shift_s && !ddr_s) ? !ph_q : ph_q;
    end
  end

  // Output enables per mode, off while buffers disabled
  always_ff @(posedge bit_clk or negedge presetn) begin
    if (!presetn) begin
      par_oe_q  <= 1'b0;
      pair_oe_q <= 1'b0;
      clk_oe_q  <= 1'b0;
    end else begin
      par_oe_q  <= en_s && !ddr_s;
      pair_oe_q <= en_s && ddr_s;
      clk_oe_q  <= en_s;
    end
  end

  assign par_data          = par_q;
  assign par_data_oe       = par_oe_q;
  assign pair_true         = ptrue_q;
  assign pair_comp         = pcomp_q;
  assign pair_oe           = pair_oe_q;
  assign output_clock      = oclk_q;
  assign output_clock_true = oclk_t_q;
  assign output_clock_comp = oclk_c_q;
  assign clock_oe          = clk_oe_q;

endmodule : aop_port

// file: tb/aop_port_asserts.sv
// Concurrent checks on the sample output port pins
`timescale 1ns/1ps
module aop_port_asserts (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin side
  input wire logic        bit_clk,
  input wire logic [11:0] par_data,
  input wire logic        par_data_oe,
  input wire logic [6:0]  pair_true,
  input wire logic [6:0]  pair_comp,
  input wire logic        pair_oe,
  input wire logic        output_clock_true,
  input wire logic        output_clock_comp,
  input wire logic        clock_oe,
  input wire logic        buffer_drive_level,
  input wire logic [1:0]  diff_current_level,
  input wire logic        current_boost,
  input wire logic [2:0]  data_pair_termination,
  input wire logic [2:0]  clock_pair_termination
);
  logic        acc;
  logic        wr;
  // Access phase and completed write
  assign acc = psel && penable;
  assign wr  = acc && pwrite && pready;

  ready_zero_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc |-> pready) else $error("access without ready");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr)
    else $error("unmapped access not flagged");
  drive_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == 8'h00 |-> ##2 buffer_drive_level == $past(pwdata[5], 2))
    else $error("drive level not written");
  current_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == 8'h04 |-> ##2
      diff_current_level == $past(pwdata[1:0], 2)
      && current_boost == $past(pwdata[2], 2))
    else $error("current setting wrong");
  term_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == 8'h04 |-> ##2
      data_pair_termination == $past(pwdata[6:4], 2)
      && clock_pair_termination == $past(pwdata[10:8], 2))
    else $error("termination wrong");
  one_mode_a: assert property (@(posedge bit_clk) disable iff (!presetn)
    !(par_data_oe && pair_oe)) else $error("both output kinds enabled");
  pair_diff_a: assert property (@(posedge bit_clk) disable iff (!presetn)
    pair_comp == ~pair_true) else $error("pair halves not inverse");
  clk_diff_a: assert property (@(posedge bit_clk) disable iff (!presetn)
    output_clock_comp == ~output_clock_true) else $error("clock pair skew");
  word_stands_a: assert property (@(posedge bit_clk) disable iff (!presetn)
    par_data_oe && $changed(par_data) |=> $stable(par_data))
    else $error("word held one cycle only");
  off_floats_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == 8'h00 && pwdata[3] |-> ##[1:40]
      !(par_data_oe || pair_oe || clock_oe)) else $error("outputs not floated");

  // Main scenarios reached
  ddr_on_c: cover property (@(posedge bit_clk) $rose(pair_oe));
  err_seen_c: cover property (@(posedge pclk) acc && pslverr);
  boost_on_c: cover property (@(posedge pclk) current_boost);
endmodule : aop_port_asserts

// file: tb/aop_rx_model.sv
// Receiver capture model at the far end of the output pins
`timescale 1ns/1ps
module aop_rx_model (
  // Forwarded clock and pins
  input  wire logic        output_clock,
  input  wire logic [11:0] par_data,
  input  wire logic        par_data_oe,
  input  wire logic [6:0]  pair_true,
  input  wire logic        pair_oe,
  // Captured words
  output logic      [11:0] par_word,
  output logic      [11:0] ddr_word
);
  logic [6:0] even_q;
  logic [6:0] odd_q;
  // Parallel word at clock rise, lost while floating
  always_ff @(posedge output_clock)
    par_word <= par_data_oe ? par_data : 'x;
  // Even bits at rise, odd bits at fall
  always_ff @(posedge output_clock)
    even_q <= pair_oe ? pair_true : 'x;
  always_ff @(negedge output_clock)
    odd_q <= pair_oe ? pair_true : 'x;
  // Interleave pairs back into a word
  always_comb
    for (int i = 0; i < 6; i++)
      ddr_word[2*i +: 2] = {odd_q[i], even_q[i]};
endmodule : aop_rx_model

// file: tb/tb_aop_port.sv
// Self-checking bench for the sample output port
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_aop_port;
  // Clocks, reset and APB
  logic        pclk = 1'b0;
  logic        bit_clk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Converter side and pins
  logic        parallel_config_pin = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic [11:0] par_data, par_word, ddr_word;
  logic [6:0]  pair_true, pair_comp;
  logic        par_data_oe, pair_oe, output_clock, output_clock_true;
  logic        output_clock_comp, clock_oe, buffer_drive_level, current_boost;
  logic [1:0]  diff_current_level;
  logic [2:0]  data_pair_termination, clock_pair_termination;
  // Bench state
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          seed = 32'h057c863e;
  logic [31:0] rd;
  logic        er;
  logic        sh = 1'b0;
  logic [11:0] par_last;
  logic        clk_at_launch;
  logic [5:0]  md [7] = '{6'h00, 6'h02, 6'h01, 6'h03, 6'h10, 6'h10, 6'h24};

  aop_port i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .parallel_config_pin, .bit_clk, .conv_data,
    .par_data, .par_data_oe, .pair_true, .pair_comp, .pair_oe,
    .output_clock, .output_clock_true, .output_clock_comp, .clock_oe,
    .buffer_drive_level, .diff_current_level, .current_boost,
    .data_pair_termination, .clock_pair_termination
  );
  aop_rx_model i_rx (.output_clock, .par_data, .par_data_oe, .pair_true,
                     .pair_oe, .par_word, .ddr_word);

  // Clocks with unrelated phase
  always #5 pclk = ~pclk;
  initial begin
    #3;
    forever begin
      bit_clk = ~bit_clk;
      #40;
    end
  end

  // Forwarded clock level just before each parallel word launch
  always @(negedge bit_clk) begin
    par_last <= par_data;
    if (par_data !== par_last)
      clk_at_launch <= output_clock;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Word as the receiver should see it
  function automatic logic [11:0] fmt(logic [11:0] v, logic of);
    return of ? {~v[11], v[10:0]} : v;
  endfunction : fmt

  // Hold a result and compare the captured word
  task automatic sample(input logic [11:0] v, input logic dd, input logic of);
    conv_data <= v;
    repeat (60) @(posedge pclk);
    if (dd) `CHK("ddr word", fmt(v, of), ddr_word)
    else begin
      `CHK("par word", fmt(v, of), par_word)
      `CHK("clock shift", sh, clk_at_launch)
    end
  endtask : sample

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    `CHK("drive", 1'b0, buffer_drive_level)
    `CHK("current", 2'h0, diff_current_level)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    // Every current code and termination combination
    for (int i = 0; i < 8; i++) begin
      logic [31:0] d;
      d = {21'h0, ~i[2:0], 1'b0, i[2:0], 1'b0, i[0], i[1:0]};
      apb(1'b1, 8'h04, d);
      apb(1'b0, 8'h04, 32'h0);
      `CHK("analog", d, rd)
      `CHK("current", i[1:0], diff_current_level)
      `CHK("boost", i[0], current_boost)
      `CHK("dterm", i[2:0], data_pair_termination)
      `CHK("cterm", ~i[2:0], clock_pair_termination)
    end
    // Every output kind and format, by bit and by pin
    for (int m = 0; m < 7; m++) begin
      logic dd, of;
      dd = md[m][4] ? (m == 5) : md[m][0];
      of = md[m][4] ? (m == 5) : md[m][1];
      sh = md[m][2];
      parallel_config_pin <= (m == 5);
      apb(1'b1, 8'h00, {26'h0, md[m]});
      repeat (60) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0);
      `CHK("status", {28'h0, m == 5, 1'b1, of, dd}, rd)
      `CHK("drive", md[m][5], buffer_drive_level)
      sample(12'h800, dd, of);
      sample(12'h7ff, dd, of);
      repeat (2) sample(12'($random(seed)), dd, of);
    end
    // Float outputs, then come back
    sh = 1'b0;
    apb(1'b1, 8'h00, 32'h8);
    repeat (30) @(posedge pclk);
    `CHK("oe off", 3'b000, {par_data_oe, pair_oe, clock_oe})
    apb(1'b1, 8'h00, 32'h0);
    repeat (50) @(posedge pclk);
    `CHK("oe on", 3'b101, {par_data_oe, pair_oe, clock_oe})
    sample(12'h5a5, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule : tb_aop_port

bind aop_port aop_port_asserts i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .bit_clk, .par_data, .par_data_oe, .pair_true, .pair_comp,
  .pair_oe, .output_clock_true, .output_clock_comp, .clock_oe,
  .buffer_drive_level, .diff_current_level, .current_boost,
  .data_pair_termination, .clock_pair_termination
);
